// ==== shared/elbpd_pkg.sv ====
/*
  Constants for the backlight pump driver: register indices and byte
  addresses, field positions, reset values and sequencer states.
  Assumes a 32-bit APB bus with one register per aligned word.
*/
package elbpd_pkg;
  // Printed register indices; byte address is four times the index
  localparam logic [7:0] IDX_RATE = 8'h18;
  localparam logic [7:0] IDX_DUTY = 8'h19;
  localparam logic [7:0] IDX_STATUS = 8'h1A;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_RATE = {2'b00, IDX_RATE, 2'b00};
  localparam logic [11:0] ADDR_DUTY = {2'b00, IDX_DUTY, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};

  // Rate register fields
  localparam int PUMP_RATE_LSB = 0;
  localparam int PUMP_RATE_MSB = 2;
  localparam int DIS_RATE_LSB = 3;
  localparam int DIS_RATE_MSB = 4;
  // Duty and enable register fields
  localparam int PUMP_DUTY_LSB = 0;
  localparam int PUMP_DUTY_MSB = 2;
  localparam int DIS_DUTY_LSB = 3;
  localparam int DIS_DUTY_MSB = 5;
  localparam int PANEL_ON_BIT = 7;

  // Pump divide 256, discharge divide 64
  localparam logic [7:0] RATE_RESET = 8'h12;
  // Pump duty 7/8, discharge duty 1/8, panel off
  localparam logic [7:0] DUTY_RESET = 8'h06;
  localparam logic [7:0] RATE_MASK = 8'h1F;
  localparam logic [7:0] DUTY_MASK = 8'hBF;
  localparam logic [2:0] PUMP_RATE_RESET = 3'h2;
  localparam logic [2:0] DIS_RATE_RESET = 3'h2;
  localparam logic [2:0] PUMP_DUTY_RESET = 3'h6;
  localparam logic [2:0] DIS_DUTY_RESET = 3'h0;

  // Divider counter widths: 1024 and 256 at the slowest setting
  localparam int PUMP_CNT_W = 10;
  localparam int DIS_CNT_W = 8;
  localparam logic [2:0] DUTY_FULL = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARM = 3'b001,
    ST_FIRST = 3'b010,
    ST_RUN = 3'b011,
    ST_LAST = 3'b100
  } elbpd_state_t;
endpackage : elbpd_pkg

// ==== shared/elbpd_phase_if.sv ====
/*
  Phase carrier between a divider and its duty generator.
  Assumes all members are driven in the pclk domain.
*/
`timescale 1ns/1ps
interface elbpd_phase_if;
  logic wrap;
  logic [2:0] eighth;
  modport src (output wrap, output eighth);
  modport snk (input wrap, input eighth);
endinterface : elbpd_phase_if

// ==== core/elbpd_divider.sv ====
/*
  Power-of-two divider of oscillator edge ticks, giving the current
  eighth of the period and a period-end strobe.
  Assumes tick is a one-cycle pulse per oscillator rising edge.
*/
`timescale 1ns/1ps
module elbpd_divider #(
  parameter int CNT_W = 10,
  parameter logic [2:0] RESET_CODE = 3'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [2:0] code,
  elbpd_phase_if.src ph
);
  import elbpd_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [2:0] code_reg;
  logic [2:0] code_next;

  // Period is 2**(CNT_W - code) ticks
  wire [3:0] log_n = 4'(CNT_W) - {1'b0, code_reg};
  wire [CNT_W-1:0] limit = CNT_W'((1 << log_n) - 1);
  wire [3:0] shift = log_n - 4'h3;
  wire at_end = (cnt_reg == limit);

  assign ph.wrap = tick && at_end;
  assign ph.eighth = 3'(cnt_reg >> shift);
  assign cnt_next = !tick ? cnt_reg : (at_end ? '0 : cnt_reg + 1'b1);
  // New rate only at a period boundary
  assign code_next = ph.wrap ? code : code_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      code_reg <= RESET_CODE;
    end else begin
      cnt_reg <= cnt_next;
      code_reg <= code_next;
    end
  end
endmodule : elbpd_divider

// ==== core/elbpd_duty_gen.sv ====
/*
  Duty waveform from the period phase: high for (code+1) eighths,
  constantly high for code 7. LATE puts the high part at period end.
  Assumes the phase interface comes from one divider.
*/
`timescale 1ns/1ps
module elbpd_duty_gen #(
  parameter bit LATE = 1'b0,
  parameter logic [2:0] RESET_CODE = 3'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] code,
  elbpd_phase_if.snk ph,
  output logic wave
);
  import elbpd_pkg::*;

  logic [2:0] code_reg;
  logic [2:0] code_next;

  wire [2:0] pos = LATE ? ~ph.eighth : ph.eighth;
  assign wave = (code_reg == DUTY_FULL) || (pos <= code_reg);
  assign code_next = ph.wrap ? code : code_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg <= RESET_CODE;
    end else begin
      code_reg <= code_next;
    end
  end
endmodule : elbpd_duty_gen

// ==== core/elbpd_top.sv ====
/*
  Backlight pump driver: APB registers, oscillator edge synchronisers,
  pump and discharge dividers and the enable/disable sequencer.
  Assumes oscillator and option inputs are asynchronous pins and that
  the fast oscillator runs below half the pclk rate.
*/
// Functional notes
// - Pump divides fast clock 1024 down to 8
// - Discharge divides slow clock 256 down to 32
// - Pump high (n+1)/8, code 7 constant
// - Discharge high (n+1)/8, code 7 constant
// - On enable, one discharge pulse before pumping
// - Discharge pulse right after each pump burst
// - On disable, final discharge then both stop
// - Pump rate follows fast oscillator frequency
// - Reset: /256, /64, 7/8, 1/8, disabled
// - Option input and enable bit both needed
`timescale 1ns/1ps
module elbpd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [elbpd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fast_osc_freq,
  input wire logic slow_osc_freq,
  input wire logic option_enable,
  output logic pump_out,
  output logic discharge_out
);
  import elbpd_pkg::*;

  logic [7:0] rate_reg;
  logic [7:0] rate_next;
  logic [7:0] duty_reg;
  logic [7:0] duty_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pslverr_reg;
  logic pump_out_reg;
  logic pump_out_next;
  logic discharge_out_reg;
  logic discharge_out_next;
  elbpd_state_t state_reg;
  elbpd_state_t state_next;

  // Two-flop synchronisers, plus an edge stage on the two oscillators only
  logic [2:0] fast_sync_reg;
  logic [2:0] slow_sync_reg;
  logic [1:0] opt_sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_sync_reg <= 3'h0;
      slow_sync_reg <= 3'h0;
      opt_sync_reg <= 2'h0;
    end else begin
      fast_sync_reg <= {fast_sync_reg[1:0], fast_osc_freq};
      slow_sync_reg <= {slow_sync_reg[1:0], slow_osc_freq};
      opt_sync_reg <= {opt_sync_reg[0], option_enable};
    end
  end

  wire fast_tick = fast_sync_reg[1] && !fast_sync_reg[2];
  wire slow_tick = slow_sync_reg[1] && !slow_sync_reg[2];
  wire option_on = opt_sync_reg[1];

  // APB decode
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable && pready_reg;
  wire sel_rate = (paddr == ADDR_RATE);
  wire sel_duty = (paddr == ADDR_DUTY);
  wire sel_status = (paddr == ADDR_STATUS);
  wire mapped = sel_rate || sel_duty || sel_status;
  wire bad_req = !mapped || (pwrite && sel_status);
  wire lane0_wr = access_ph && pwrite && pstrb[0] && !pslverr_reg;
  wire [7:0] wdata_b = pwdata[7:0];
  wire wr_rate = lane0_wr && sel_rate;
  wire wr_duty = lane0_wr && sel_duty;

  assign rate_next = wr_rate ? (wdata_b & RATE_MASK) : rate_reg;
  assign duty_next = wr_duty ? (wdata_b & DUTY_MASK) : duty_reg;

  wire [7:0] status_val = {2'b00, option_on, discharge_out_reg, pump_out_reg, state_reg};
  wire [7:0] read_byte = sel_rate ? rate_reg :
                         sel_duty ? duty_reg :
                         sel_status ? status_val : 8'h00;
  assign prdata_next = setup_ph ? {24'h000000, read_byte} : prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_reg <= RATE_RESET;
      duty_reg <= DUTY_RESET;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      rate_reg <= rate_next;
      duty_reg <= duty_next;
      prdata_reg <= prdata_next;
      pready_reg <= setup_ph;
      pslverr_reg <= setup_ph && bad_req;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // Dividers and duty generators
  elbpd_phase_if pump_ph ();
  elbpd_phase_if dis_ph ();
  logic pump_wave;
  logic dis_wave;

  elbpd_divider #(
    .CNT_W(PUMP_CNT_W),
    .RESET_CODE(PUMP_RATE_RESET)
  ) u_pump_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(fast_tick),
    .code(rate_reg[PUMP_RATE_MSB:PUMP_RATE_LSB]),
    .ph(pump_ph)
  );

  elbpd_divider #(
    .CNT_W(DIS_CNT_W),
    .RESET_CODE(DIS_RATE_RESET)
  ) u_dis_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(slow_tick),
    .code({1'b0, rate_reg[DIS_RATE_MSB:DIS_RATE_LSB]}),
    .ph(dis_ph)
  );

  elbpd_duty_gen #(
    .LATE(1'b0),
    .RESET_CODE(PUMP_DUTY_RESET)
  ) u_pump_duty (
    .pclk(pclk),
    .presetn(presetn),
    .code(duty_reg[PUMP_DUTY_MSB:PUMP_DUTY_LSB]),
    .ph(pump_ph),
    .wave(pump_wave)
  );

  // Discharge high part sits at the end of its period, after the burst
  elbpd_duty_gen #(
    .LATE(1'b1),
    .RESET_CODE(DIS_DUTY_RESET)
  ) u_dis_duty (
    .pclk(pclk),
    .presetn(presetn),
    .code(duty_reg[DIS_DUTY_MSB:DIS_DUTY_LSB]),
    .ph(dis_ph),
    .wave(dis_wave)
  );

  // Sequencer
  wire run_en = duty_reg[PANEL_ON_BIT] && option_on;
  wire dis_wrap = dis_ph.wrap;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (run_en) state_next = ST_ARM;
      end
      ST_ARM: begin
        if (!run_en) state_next = ST_IDLE;
        else if (dis_wrap) state_next = ST_FIRST;
      end
      ST_FIRST: begin
        // One whole discharge period with no pumping
        if (dis_wrap) state_next = run_en ? ST_RUN : ST_IDLE;
      end
      ST_RUN: begin
        if (!run_en) state_next = ST_LAST;
      end
      ST_LAST: begin
        // Finish the current period so its closing pulse is emitted
        if (dis_wrap) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  wire dis_active = (state_reg == ST_FIRST) || (state_reg == ST_RUN) || (state_reg == ST_LAST);
  assign pump_out_next = (state_reg == ST_RUN) && pump_wave && !dis_wave;
  assign discharge_out_next = dis_active && dis_wave;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      pump_out_reg <= 1'b0;
      discharge_out_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pump_out_reg <= pump_out_next;
      discharge_out_reg <= discharge_out_next;
    end
  end

  assign pump_out = pump_out_reg;
  assign discharge_out = discharge_out_reg;

  // Checks
  chk_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_IDLE) |=> (!pump_out_reg && !discharge_out_reg))
    else $error("outputs active while idle");
  chk_first_no_pump: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_FIRST) |=> !pump_out_reg)
    else $error("pump during first discharge period");
  chk_last_no_pump: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_LAST) |=> !pump_out_reg)
    else $error("pump after disable");
  chk_burst_gate: assert property (@(posedge pclk) disable iff (!presetn)
    pump_out_reg |-> !discharge_out_reg)
    else $error("pump and discharge high together");
  chk_enable_arm: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_IDLE && run_en) |=> (state_reg == ST_ARM))
    else $error("enable not taken");
  chk_disable_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_RUN && !run_en) |=> (state_reg == ST_LAST))
    else $error("disable not taken");
  chk_last_ends: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_LAST && dis_wrap) |=> (state_reg == ST_IDLE) ##1 !discharge_out_reg)
    else $error("final discharge did not end");
  chk_option_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_IDLE && !option_on) |=> (state_reg == ST_IDLE))
    else $error("left idle without option");
  chk_rate_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_rate |=> (rate_reg == ($past(wdata_b) & RATE_MASK)))
    else $error("rate register write lost");
  chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph |=> pready_reg ##1 !pready_reg)
    else $error("pready not one access cycle");
  chk_first_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_FIRST && dis_wrap) |=> discharge_out_reg)
    else $error("no discharge pulse ending first period");
  chk_run_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_RUN && dis_wrap) |=> discharge_out_reg)
    else $error("no discharge pulse after burst");
  chk_last_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_LAST && dis_wrap) |=> discharge_out_reg)
    else $error("no final discharge pulse");
  chk_arm_first: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_ARM && run_en && dis_wrap) |=> (state_reg == ST_FIRST))
    else $error("first discharge period not started");
  chk_first_run: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_FIRST && run_en && dis_wrap) |=> (state_reg == ST_RUN))
    else $error("pumping not started after first pulse");
  chk_arm_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_ARM) |=> (!pump_out_reg && !discharge_out_reg))
    else $error("outputs active while arming");
  chk_duty_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_duty |=> (duty_reg == ($past(wdata_b) & DUTY_MASK)))
    else $error("duty register write lost");
  chk_rate_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_rate |=> $stable(rate_reg))
    else $error("rate register changed without write");
  chk_duty_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_duty |=> $stable(duty_reg))
    else $error("duty register changed without write");
  chk_err_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_ph && pslverr_reg) |=> ($stable(rate_reg) && $stable(duty_reg)))
    else $error("refused access changed a register");
  chk_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !mapped) |=> (pready_reg && pslverr_reg))
    else $error("unmapped access not refused");
  chk_read_data: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && sel_rate) |=> (prdata_reg == {24'h000000, $past(rate_reg)}))
    else $error("rate register read data wrong");
  chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready_reg |-> $past(setup_ph))
    else $error("pready without setup cycle");
  chk_pump_phase: assert property (@(posedge pclk) disable iff (!presetn)
    pump_ph.wrap |-> (pump_ph.eighth == 3'h7))
    else $error("pump period ends off its last eighth");
  chk_dis_phase: assert property (@(posedge pclk) disable iff (!presetn)
    dis_ph.wrap |-> (dis_ph.eighth == 3'h7))
    else $error("discharge period ends off its last eighth");

  cov_run: cover property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_FIRST) ##1 (state_reg == ST_RUN));
  cov_pump_then_dis: cover property (@(posedge pclk) disable iff (!presetn)
    pump_out_reg ##[1:1000] discharge_out_reg);
  cov_shutdown: cover property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_LAST) ##1 (state_reg == ST_IDLE));
  cov_arm_abort: cover property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_ARM) && !run_en);
  cov_bad_access: cover property (@(posedge pclk) disable iff (!presetn)
    access_ph && pslverr_reg);
endmodule : elbpd_top

// ==== verification/elbpd_panel_model.sv ====
/*
  Pump, inductor and panel model: pump rises build charge, discharge high
  clears it. Assumes both drive inputs are pclk-domain registered outputs.
*/
`timescale 1ns/1ps
module elbpd_panel_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic pump_out,
  input wire logic discharge_out,
  output int charge,
  output int burst,
  output logic first_dis,
  output logic pump_in_clear
);
  logic pump_q;
  logic dis_q;
  logic seen;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_q <= 1'b0;
      dis_q <= 1'b0;
      seen <= 1'b0;
      charge <= 0;
      burst <= 0;
      first_dis <= 1'b0;
      pump_in_clear <= 1'b0;
    end else begin
      pump_q <= pump_out;
      dis_q <= discharge_out;
      // Discharge switch shorts the panel
      if (discharge_out) begin
        if (charge != 0) burst <= charge;
        charge <= 0;
      end else if (pump_out && !pump_q) begin
        charge <= charge + 1;
      end
      if (pump_out && !pump_q && discharge_out) pump_in_clear <= 1'b1;
      if (restart) begin
        seen <= 1'b0;
        pump_in_clear <= 1'b0;
      end else if (!seen && ((pump_out && !pump_q) || (discharge_out && !dis_q))) begin
        seen <= 1'b1;
        first_dis <= discharge_out && !dis_q;
      end
    end
  end
endmodule : elbpd_panel_model

// ==== verification/tb_el_backlight_pump_driver.sv ====
/*
  Self-checking bench for the backlight pump driver over APB.
  Assumes the panel model file is compiled before this one.
*/
`timescale 1ns/1ps
module tb_el_backlight_pump_driver;
  import elbpd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, restart;
  logic option_enable, fast_osc_freq, slow_osc_freq, pump_out, discharge_out, first_dis, pump_in_clear;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  int n_mismatch = 0, num_checks = 0, cyc = 0, charge, burst;
  realtime fast_half = 250.0;
  elbpd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_osc_freq(fast_osc_freq), .slow_osc_freq(slow_osc_freq), .option_enable(option_enable),
    .pump_out(pump_out), .discharge_out(discharge_out));
  elbpd_panel_model u_panel (.pclk(pclk), .presetn(presetn), .restart(restart), .pump_out(pump_out),
    .discharge_out(discharge_out), .charge(charge), .burst(burst), .first_dis(first_dis),
    .pump_in_clear(pump_in_clear));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Oscillators unrelated in phase to pclk
  initial begin
    fast_osc_freq = 1'b0;
    #37;
    forever #(fast_half) fast_osc_freq = ~fast_osc_freq;
  end
  initial begin
    slow_osc_freq = 1'b0;
    #11;
    forever #15259 slow_osc_freq = ~slow_osc_freq;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end
  task report_and_stop;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task near(input string what, input int exp, input int got, input int tol);
    num_checks++;
    if (got < exp - tol || got > exp + tol) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : near
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready wait", 1, n);
  endtask : apb
  function automatic logic sig(input bit d);
    return d ? discharge_out : pump_out;
  endfunction : sig
  task wait_lvl(input bit d, input logic v, input int lim, output int t);
    t = 0;
    while (sig(d) !== v && t < lim) begin
      @(posedge pclk);
      t++;
    end
  endtask : wait_lvl
  task t_pump(input int h);
    int t, hi, lo;
    wait_lvl(0, 0, 400, t);
    wait_lvl(0, 1, 400, t);
    wait_lvl(0, 0, 400, hi);
    wait_lvl(0, 1, 400, lo);
    near("pump high", h, hi, 1);
    near("pump low", h, lo, 1);
  endtask : t_pump
  task t_reset;
    apb(0, ADDR_RATE, 0);
    check("rate reset", 32'(RATE_RESET), rd);
    apb(0, ADDR_DUTY, 0);
    check("duty reset", 32'(DUTY_RESET), rd);
    check("outputs idle", 0, {pump_out, discharge_out});
    apb(0, ADDR_STATUS, 0);
    check("status idle", 0, rd);
    apb(0, 12'h000, 0);
    check("unmapped err", 1, err);
  endtask : t_reset
  task t_regs;
    apb(1, ADDR_RATE, 32'hFF);
    apb(0, ADDR_RATE, 0);
    check("rate rw", 32'h1F, rd);
    apb(1, ADDR_DUTY, 32'h7F);
    apb(0, ADDR_DUTY, 0);
    check("duty rw", 32'h3F, rd);
  endtask : t_regs
  task t_option;
    int hits;
    hits = 0;
    apb(1, ADDR_DUTY, 32'h83);
    repeat (10000) begin
      @(posedge pclk);
      if (pump_out || discharge_out) hits++;
    end
    check("option gate", 0, hits);
  endtask : t_option
  task t_run;
    int t, t1, hi, hits;
    hits = 0;
    restart <= 1'b1;
    option_enable <= 1'b1;
    @(posedge pclk);
    restart <= 1'b0;
    wait_lvl(1, 1, 25000, t);
    t1 = cyc;
    wait_lvl(1, 0, 2000, hi);
    near("discharge high", 1221, hi, 3);
    check("first pulse", 1, first_dis);
    t_pump(20);
    fast_half = 1000.0;
    repeat (400) @(posedge pclk);
    t_pump(80);
    fast_half = 250.0;
    wait_lvl(1, 1, 10000, t);
    near("discharge period", 9766, cyc - t1, 3);
    wait_lvl(1, 0, 2000, hi);
    check("burst pumped", 1, burst > 0);
    check("pump in clear", 0, pump_in_clear);
    repeat (2000) @(posedge pclk);
    apb(1, ADDR_DUTY, 32'h03);
    wait_lvl(1, 1, 10000, t);
    wait_lvl(1, 0, 2000, hi);
    near("final pulse", 1221, hi, 3);
    repeat (400) begin
      @(posedge pclk);
      if (pump_out || discharge_out) hits++;
    end
    check("stopped", 0, hits);
    check("panel charge", 0, charge);
  endtask : t_run
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    option_enable = 1'b0;
    restart = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_option();
    t_run();
    report_and_stop();
  end
endmodule : tb_el_backlight_pump_driver
